// file: hdl/ext_bus_wait_ctrl.sv
// External bus interface unit with its wait state controller.
//
// What this block does
// - Wait count chosen by control bits 7:6.
// - Field 00/01: memory one wait, I/O two.
// - Field 10/11: faster upper memory, I/O one.
// - Field 01 widens the memory write strobe.
// - Memory split in halves on address bit 19.
// - Internal strobes become four external strobes.
// - On-chip accesses leave external strobes high.
// - On-chip accesses always get zero waits.
// - Own wait merged with external wait request.
// - Zero-wait accesses ignore the external request.
// - External waits follow the controller's waits.
// - CPU waits while its wait input low.
// - I/O strobes two cycles, memory one minimum.
`timescale 1ns/1ps
module ext_bus_wait_ctrl
   import ext_bus_wait_pkg::*;
(
   input wire logic REF_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic INT_MEM_READ_N_I,
   input wire logic INT_MEM_WRITE_N_I,
   input wire logic INT_IO_READ_N_I,
   input wire logic INT_IO_WRITE_N_I,
   input wire logic ON_CHIP_I,
   input wire logic [19:0] PHYS_ADDR_I,
   input wire logic [7:0] WR_DATA_I,
   input wire logic SCR_WRITE_I,
   input wire logic [7:0] SCR_DATA_I,
   input wire logic EXT_WAIT_REQUEST_I,
   output logic EXT_MEM_READ_STROBE_N_O,
   output logic EXT_MEM_WRITE_STROBE_N_O,
   output logic EXT_IO_READ_STROBE_N_O,
   output logic EXT_IO_WRITE_STROBE_N_O,
   output logic [19:0] EXT_ADDR_O,
   output logic [7:0] EXT_WDATA_O,
   output logic CPU_WAIT_N_O,
   output logic [7:0] SYSTEM_CONTROL_REG_B_O
);

   // ***************************************************************
   // Declarations.
   // ***************************************************************

   // Sequencer state and its next value.
   bus_state_t state_reg;
   bus_state_t state_next;
   // Controller wait states still to insert.
   logic [1:0] wait_cnt_reg;
   // The running access may be stretched by the external request.
   logic ext_ok_reg;
   // The running access is a widened memory write.
   logic wide_reg;
   // Filtered external wait request.
   logic ext_wait;
   // Some internal strobe is active.
   logic any_strobe;
   // Internal I/O strobe is active.
   logic is_io;
   // Start of an external access in this cycle.
   logic start;
   // Wait states for the access being started.
   logic [1:0] start_waits;
   // Internal strobe of the running access is still active.
   logic strobe_held;

   // Computes the controller wait count for one external access.
   function automatic logic [1:0] wait_count(input logic [1:0] sel,
                                             input logic io,
                                             input logic upper);
      logic [1:0] n;
      n = WAITS_ONE;
      case (sel)
         SEL_SLOW, SEL_SLOW_WIDE:
         begin
            n = io ? WAITS_TWO : WAITS_ONE;
         end
         SEL_SPLIT:
         begin
            n = (io || !upper) ? WAITS_ONE : WAITS_ZERO;
         end
         SEL_FAST:
         begin
            n = io ? WAITS_ONE : WAITS_ZERO;
         end
         default:
         begin
            n = WAITS_ONE;
         end
      endcase
      return n;
   endfunction

   // ***************************************************************
   // External wait request input.
   // ***************************************************************

   // Brings the asynchronous pin into the clock domain.
   pin_sync3 u_wait_sync (
      .clk_i(REF_CLK_I),
      .rst_i(SYS_RST_I),
      .pin_i(EXT_WAIT_REQUEST_I),
      .level_o(ext_wait)
   );

   // ***************************************************************
   // Access decode.
   // ***************************************************************

   // Classifies the internal strobes and picks the wait count.
   always_comb
   begin
      is_io = !INT_IO_READ_N_I || !INT_IO_WRITE_N_I;
      any_strobe = is_io || !INT_MEM_READ_N_I || !INT_MEM_WRITE_N_I;
      // On-chip targets never start an external access.
      start = (state_reg == ST_IDLE) && any_strobe && !ON_CHIP_I;
      start_waits = wait_count(
         SYSTEM_CONTROL_REG_B_O[WAIT_SEL_MSB:WAIT_SEL_LSB],
         is_io, PHYS_ADDR_I[UPPER_HALF_BIT]);
   end

   // True while the strobe kind that started the access stays active.
   always_comb
   begin
      strobe_held = (!EXT_MEM_READ_STROBE_N_O && !INT_MEM_READ_N_I) ||
                    (!EXT_MEM_WRITE_STROBE_N_O && !INT_MEM_WRITE_N_I) ||
                    (!EXT_IO_READ_STROBE_N_O && !INT_IO_READ_N_I) ||
                    (!EXT_IO_WRITE_STROBE_N_O && !INT_IO_WRITE_N_I);
   end

   // ***************************************************************
   // Control register.
   // ***************************************************************

   // Holds the wait-select field; it powers up at the slowest timing.
   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
   begin
      if (SYS_RST_I)
      begin
         SYSTEM_CONTROL_REG_B_O <= SCR_RESET;
      end
      else if (SCR_WRITE_I)
      begin
         SYSTEM_CONTROL_REG_B_O <= SCR_DATA_I;
      end
   end

   // ***************************************************************
   // Sequencer.
   // ***************************************************************

   // Chooses the next state from the internal strobes.
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (start)
            begin
               state_next = ST_ACTIVE;
            end
         end
         ST_ACTIVE:
         begin
            // The CPU ends its strobe only after the last wait.
            if (!strobe_held)
            begin
               state_next = wide_reg ? ST_WIDE : ST_IDLE;
            end
         end
         ST_WIDE:
         begin
            state_next = ST_IDLE;
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Advances the sequencer.
   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
   begin
      if (SYS_RST_I)
      begin
         state_reg <= ST_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Latches the per-access attributes at the start.
   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
   begin
      if (SYS_RST_I)
      begin
         ext_ok_reg <= 1'b0;
         wide_reg <= 1'b0;
      end
      else if (start)
      begin
         // Zero-wait accesses never look at the request pin.
         ext_ok_reg <= (start_waits != WAITS_ZERO);
         wide_reg <= !INT_MEM_WRITE_N_I &&
            (SYSTEM_CONTROL_REG_B_O[WAIT_SEL_MSB:WAIT_SEL_LSB] ==
             SEL_SLOW_WIDE);
      end
   end

   // ***************************************************************
   // Wait generation.
   // ***************************************************************

   // Counts the controller waits, then lets the pin add more.
   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
   begin
      if (SYS_RST_I)
      begin
         wait_cnt_reg <= WAITS_ZERO;
         CPU_WAIT_N_O <= 1'b1;
      end
      else if (start)
      begin
         wait_cnt_reg <= start_waits;
         CPU_WAIT_N_O <= (start_waits == WAITS_ZERO);
      end
      else if (state_reg == ST_ACTIVE && wait_cnt_reg > WAITS_ONE)
      begin
         wait_cnt_reg <= wait_cnt_reg - WAITS_ONE;
         CPU_WAIT_N_O <= 1'b0;
      end
      else if (state_reg == ST_ACTIVE && strobe_held)
      begin
         // External waits come after the controller's own.
         wait_cnt_reg <= WAITS_ZERO;
         CPU_WAIT_N_O <= !(ext_ok_reg && ext_wait);
      end
      else
      begin
         wait_cnt_reg <= WAITS_ZERO;
         CPU_WAIT_N_O <= 1'b1;
      end
   end

   // ***************************************************************
   // External strobes, address and data.
   // ***************************************************************

   // Drives the strobe that matches the internal one.
   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
   begin
      if (SYS_RST_I)
      begin
         EXT_MEM_READ_STROBE_N_O <= 1'b1;
         EXT_MEM_WRITE_STROBE_N_O <= 1'b1;
         EXT_IO_READ_STROBE_N_O <= 1'b1;
         EXT_IO_WRITE_STROBE_N_O <= 1'b1;
      end
      else if (start)
      begin
         EXT_MEM_READ_STROBE_N_O <= INT_MEM_READ_N_I;
         EXT_MEM_WRITE_STROBE_N_O <= INT_MEM_WRITE_N_I;
         EXT_IO_READ_STROBE_N_O <= INT_IO_READ_N_I;
         EXT_IO_WRITE_STROBE_N_O <= INT_IO_WRITE_N_I;
      end
      else if (state_next == ST_IDLE)
      begin
         EXT_MEM_READ_STROBE_N_O <= 1'b1;
         EXT_MEM_WRITE_STROBE_N_O <= 1'b1;
         EXT_IO_READ_STROBE_N_O <= 1'b1;
         EXT_IO_WRITE_STROBE_N_O <= 1'b1;
      end
   end

   // Captures address and data once and holds them to the end.
   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
   begin
      if (SYS_RST_I)
      begin
         EXT_ADDR_O <= 20'h00000;
         EXT_WDATA_O <= 8'h00;
      end
      else if (start)
      begin
         EXT_ADDR_O <= PHYS_ADDR_I;
         EXT_WDATA_O <= WR_DATA_I;
      end
   end

   // ***************************************************************
   // Assertions.
   // ***************************************************************

   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (SYS_RST_I);

   // Field changes only through a control write.
   field_write_only_a: assert property (
      !$stable(SYSTEM_CONTROL_REG_B_O) |-> $past(SCR_WRITE_I))
      else $error("control field changed without a write");

   // Slow field: I/O access waits at least two controller cycles.
   slow_io_waits_a: assert property (
      (start && is_io &&
       !SYSTEM_CONTROL_REG_B_O[WAIT_SEL_MSB])
      |=> !CPU_WAIT_N_O [*2])
      else $error("slow I/O access lacks two waits");

   // Fast field: memory access gets no wait at all.
   fast_mem_nowait_a: assert property (
      (start && !is_io &&
       SYSTEM_CONTROL_REG_B_O[WAIT_SEL_MSB:WAIT_SEL_LSB] == SEL_FAST)
      |=> CPU_WAIT_N_O [*2])
      else $error("fast memory access got a wait");

   // Widened write keeps its strobe one cycle past the internal one.
   wide_write_tail_a: assert property (
      (state_reg == ST_ACTIVE && wide_reg && !strobe_held)
      |=> !EXT_MEM_WRITE_STROBE_N_O ##1 EXT_MEM_WRITE_STROBE_N_O)
      else $error("widened write strobe has wrong length");

   // A memory read start asserts the external read strobe.
   read_strobe_a: assert property (
      (start && !INT_MEM_READ_N_I) |=> !EXT_MEM_READ_STROBE_N_O)
      else $error("external read strobe missing");

   // On-chip accesses leave every external strobe high.
   on_chip_quiet_a: assert property (
      (state_reg == ST_IDLE && ON_CHIP_I) |=>
      (EXT_MEM_READ_STROBE_N_O && EXT_MEM_WRITE_STROBE_N_O &&
       EXT_IO_READ_STROBE_N_O && EXT_IO_WRITE_STROBE_N_O))
      else $error("strobe driven on on-chip access");

   // On-chip accesses never see a wait.
   on_chip_nowait_a: assert property (
      (state_reg == ST_IDLE && ON_CHIP_I) |=> CPU_WAIT_N_O)
      else $error("wait driven on on-chip access");

   // Request during a one-wait access extends the wait.
   ext_wait_merge_a: assert property (
      (state_reg == ST_ACTIVE && ext_ok_reg && ext_wait &&
       strobe_held && wait_cnt_reg <= WAITS_ONE) |=> !CPU_WAIT_N_O)
      else $error("external wait request not passed on");

   // Zero-wait accesses keep the CPU running whatever the pin does.
   zero_wait_ignore_a: assert property (
      (state_reg == ST_ACTIVE && !ext_ok_reg) |=> CPU_WAIT_N_O)
      else $error("zero-wait access stalled by request pin");

   // Address stays put during an access.
   addr_hold_a: assert property (
      (state_reg != ST_IDLE && !start) |=> $stable(EXT_ADDR_O))
      else $error("address moved during access");

   // Main scenarios.
   io_stretched_c: cover property (
      start && is_io ##1 ext_wait [*3]);
   wide_write_c: cover property (state_reg == ST_WIDE);
   split_upper_c: cover property (
      start && PHYS_ADDR_I[UPPER_HALF_BIT] &&
      SYSTEM_CONTROL_REG_B_O[WAIT_SEL_MSB:WAIT_SEL_LSB] == SEL_SPLIT);

endmodule // ext_bus_wait_ctrl

// file: hdl/ext_bus_wait_pkg.sv
// Shared constants and types of the external bus wait controller.
package ext_bus_wait_pkg;

   // ***************************************************************
   // Control register layout.
   // ***************************************************************

   // Width of the second system control register.
   localparam int unsigned SCR_WIDTH = 8;
   // Lowest bit of the wait-select field.
   localparam int unsigned WAIT_SEL_LSB = 6;
   // Highest bit of the wait-select field.
   localparam int unsigned WAIT_SEL_MSB = 7;
   // Value of the whole control register after reset.
   localparam logic [7:0] SCR_RESET = 8'h00;
   // Value of the wait-select field after reset, the slowest timing.
   localparam logic [1:0] WAIT_SEL_RESET = 2'h0;

   // ***************************************************************
   // Wait-select field encodings.
   // ***************************************************************

   // Slow timing, normal write strobe.
   localparam logic [1:0] SEL_SLOW = 2'h0;
   // Slow timing with the widened memory write strobe.
   localparam logic [1:0] SEL_SLOW_WIDE = 2'h1;
   // Fast upper memory half, slow lower half.
   localparam logic [1:0] SEL_SPLIT = 2'h2;
   // Fast memory in both halves.
   localparam logic [1:0] SEL_FAST = 2'h3;

   // ***************************************************************
   // Address map and wait counts.
   // ***************************************************************

   // Width of the physical address, a 1MB space.
   localparam int unsigned PHYS_ADDR_WIDTH = 20;
   // Address bit that marks the upper half (80000 and above).
   localparam int unsigned UPPER_HALF_BIT = 19;
   // Width of the wait counter.
   localparam int unsigned WAIT_CNT_WIDTH = 2;
   // No wait state.
   localparam logic [1:0] WAITS_ZERO = 2'h0;
   // One wait state.
   localparam logic [1:0] WAITS_ONE = 2'h1;
   // Two wait states.
   localparam logic [1:0] WAITS_TWO = 2'h2;

   // ***************************************************************
   // Sequencer states.
   // ***************************************************************

   // Idle, access running, and widened write tail.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_WIDE = 2'b10
   } bus_state_t;

endpackage : ext_bus_wait_pkg

// file: hdl/pin_sync3.sv
// Three-stage input synchroniser with an agreement filter.
`timescale 1ns/1ps
module pin_sync3
   import ext_bus_wait_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pin_i,
   output logic level_o
);

   // First stage; read only by the second stage.
   logic meta_reg;
   // Second stage.
   logic stage2_reg;
   // Third stage.
   logic stage3_reg;

   // ***************************************************************
   // Synchroniser chain.
   // ***************************************************************

   // Shifts the pin through three flip-flops to settle metastability.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_reg <= 1'b0;
         stage2_reg <= 1'b0;
         stage3_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= pin_i;
         stage2_reg <= meta_reg;
         stage3_reg <= stage2_reg;
      end
   end

   // ***************************************************************
   // Agreement filter.
   // ***************************************************************

   // Takes a new level only once the second and third stages agree.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         level_o <= 1'b0;
      end
      else if (stage2_reg == stage3_reg)
      begin
         level_o <= stage3_reg;
      end
   end

endmodule // pin_sync3

// file: tb/ext_slave_model.sv
// Behavioural model of the external memories and I/O devices.
`timescale 1ns/1ps
module ext_slave_model
(
   input wire logic clk_i,
   input wire logic mem_rd_n_i,
   input wire logic mem_wr_n_i,
   input wire logic io_rd_n_i,
   input wire logic io_wr_n_i,
   input wire logic [7:0] wdata_i,
   input wire logic stall_i,
   output logic wait_request_o,
   output logic [7:0] last_wdata_o,
   output logic [7:0] read_count_o
);
   // ***************************************************************
   // Slow slave and write capture.
   // ***************************************************************

   // Combined write strobe level one clock earlier.
   logic wr_prev_reg = 1'b1;
   // Some read strobe is low.
   logic rd_any;
   // Read strobe activity one clock earlier.
   logic rd_prev_reg = 1'b0;
   // Completed external reads, so the bench can see each strobe pulse.
   logic [7:0] reads_reg = 8'h00;

   assign rd_any = ~(mem_rd_n_i & io_rd_n_i);
   assign read_count_o = reads_reg;

   // A slow device asks for waits while the bench tells it to stall.
   assign wait_request_o = stall_i;

   // Store write data at the trailing edge of either write strobe.
   always_ff @(posedge clk_i)
   begin
      wr_prev_reg <= mem_wr_n_i & io_wr_n_i;
      if (!wr_prev_reg && mem_wr_n_i && io_wr_n_i)
      begin
         last_wdata_o <= wdata_i;
      end
   end

   // Counts one read at the trailing edge of either read strobe.
   always_ff @(posedge clk_i)
   begin
      rd_prev_reg <= rd_any;
      if (rd_prev_reg && !rd_any)
      begin
         reads_reg <= reads_reg + 8'h01;
      end
   end
endmodule // ext_slave_model

// file: tb/external_bus_wait_controller_test.sv
// Self-checking testbench of the external bus wait controller.
`timescale 1ns/1ps
module external_bus_wait_controller_test
   import ext_bus_wait_pkg::*;
;
   // ***************************************************************
   // Signals.
   // ***************************************************************

   logic clk;
   logic rst;
   // Internal strobes: memory read, memory write, I/O read, I/O write.
   logic [3:0] istb;
   logic on_chip;
   logic [19:0] addr;
   logic [7:0] wdata;
   logic scr_wr;
   logic [7:0] scr_data;
   // Tells the slave model to request waits.
   logic stall;
   logic ext_req;
   // External strobes in the same order as the internal ones.
   logic [3:0] ext_n;
   logic [19:0] eaddr;
   logic [7:0] ewdata;
   logic cpu_wait_n;
   logic [7:0] scr_q;
   logic [7:0] last_wd;
   // Reads that the slave model has seen complete.
   logic [7:0] n_reads;
   int fails;
   int n_tests;

   // ***************************************************************
   // Design and slave model.
   // ***************************************************************

   ext_bus_wait_ctrl u_dut (
      .REF_CLK_I(clk), .SYS_RST_I(rst),
      .INT_MEM_READ_N_I(istb[0]), .INT_MEM_WRITE_N_I(istb[1]),
      .INT_IO_READ_N_I(istb[2]), .INT_IO_WRITE_N_I(istb[3]),
      .ON_CHIP_I(on_chip), .PHYS_ADDR_I(addr), .WR_DATA_I(wdata),
      .SCR_WRITE_I(scr_wr), .SCR_DATA_I(scr_data),
      .EXT_WAIT_REQUEST_I(ext_req),
      .EXT_MEM_READ_STROBE_N_O(ext_n[0]),
      .EXT_MEM_WRITE_STROBE_N_O(ext_n[1]),
      .EXT_IO_READ_STROBE_N_O(ext_n[2]),
      .EXT_IO_WRITE_STROBE_N_O(ext_n[3]),
      .EXT_ADDR_O(eaddr), .EXT_WDATA_O(ewdata),
      .CPU_WAIT_N_O(cpu_wait_n), .SYSTEM_CONTROL_REG_B_O(scr_q));

   ext_slave_model u_slave (
      .clk_i(clk), .mem_rd_n_i(ext_n[0]), .mem_wr_n_i(ext_n[1]),
      .io_rd_n_i(ext_n[2]), .io_wr_n_i(ext_n[3]), .wdata_i(ewdata),
      .stall_i(stall), .wait_request_o(ext_req),
      .last_wdata_o(last_wd), .read_count_o(n_reads));

   // Clock of 5 ns period.
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ***************************************************************
   // Shared tasks.
   // ***************************************************************

   // Counts a comparison and reports a difference.
   task automatic check(input string what, input logic [19:0] seen,
                        input logic [19:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
      begin
         $display("All checks passed");
      end
      else
      begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Loads the control register with a wait-select field.
   task automatic set_field(input logic [1:0] f);
      @(posedge clk);
      #1;
      scr_wr = 1'b1;
      scr_data = {f, 6'h15};
      @(posedge clk);
      #1;
      scr_wr = 1'b0;
      check("control", 20'(scr_q), 20'({f, 6'h15}));
   endtask

   // One CPU access of kind k; counts waits and release cycles.
   task automatic access(input int k, input logic [19:0] a, input logic oc,
                         input int drop, output int w, output int tail);
      int n;
      logic [3:0] exp;
      w = 0;
      exp = oc ? 4'hf : (4'hf & ~(4'h1 << k));
      @(posedge clk);
      #1;
      addr = a;
      wdata = a[7:0] ^ 8'h5a;
      on_chip = oc;
      istb[k] = 1'b0;
      @(posedge clk);
      #1;
      check("strobes", 20'(ext_n), 20'(exp));
      if (!oc && k[0])
      begin
         check("write data", 20'(ewdata), 20'(wdata));
      end
      n = 0;
      while (cpu_wait_n === 1'b0 && n < 40)
      begin
         w++;
         if (w == drop)
         begin
            stall = 1'b0;
         end
         @(posedge clk);
         #1;
         n++;
         check("held strobe", 20'(ext_n), 20'(exp));
         check("held address", eaddr, a);
      end
      if (n == 40)
      begin
         fails++;
         print_verdict();
      end
      // The CPU leaves its strobe only once its wait input is high.
      istb[k] = 1'b1;
      n = 0;
      while (ext_n !== 4'hf && n < 4)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 4)
      begin
         fails++;
         print_verdict();
      end
      tail = n;
      on_chip = 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // Access with fixed expected wait count and strobe tail.
   task automatic run(input int k, input logic [19:0] a, input logic oc,
                      input int ew, input int et);
      int w;
      int t;
      access(k, a, oc, 0, w, t);
      check("waits", 20'(w), 20'(ew));
      check("tail", 20'(t), 20'(et));
   endtask

   // ***************************************************************
   // Scenarios.
   // ***************************************************************

   // Outputs straight after reset.
   task automatic reset_values();
      check("control", 20'(scr_q), 20'(SCR_RESET));
      check("idle strobes", 20'(ext_n), 20'h0000f);
      check("idle wait", 20'(cpu_wait_n), 20'h1);
   endtask

   // Slow timing for every kind, both memory halves.
   task automatic slow_field();
      set_field(SEL_SLOW);
      run(0, 20'h01234, 1'b0, 1, 1);
      run(0, 20'h80010, 1'b0, 1, 1);
      run(1, 20'h7ffff, 1'b0, 1, 1);
      check("slave data", 20'(last_wd), 20'(8'hff ^ 8'h5a));
      run(2, 20'h00042, 1'b0, 2, 1);
      run(3, 20'h000a5, 1'b0, 2, 1);
      check("slave reads", 20'(n_reads), 20'h3);
   endtask

   // Field 01 widens only the memory write strobe.
   task automatic wide_write();
      set_field(SEL_SLOW_WIDE);
      run(1, 20'h00100, 1'b0, 1, 2);
      run(1, 20'h80100, 1'b0, 1, 2);
      run(0, 20'h00100, 1'b0, 1, 1);
      run(3, 20'h00010, 1'b0, 2, 1);
   endtask

   // Field 10: upper memory fast, lower slow, I/O one wait.
   task automatic split_field();
      set_field(SEL_SPLIT);
      run(0, 20'h7ffff, 1'b0, 1, 1);
      run(0, 20'h80000, 1'b0, 0, 1);
      run(1, 20'h80000, 1'b0, 0, 1);
      run(2, 20'h00077, 1'b0, 1, 1);
   endtask

   // Field 11: no memory waits, even with the request pin raised.
   task automatic fast_field();
      set_field(SEL_FAST);
      run(0, 20'h00000, 1'b0, 0, 1);
      run(1, 20'hfffff, 1'b0, 0, 1);
      run(3, 20'h00011, 1'b0, 1, 1);
      #1;
      stall = 1'b1;
      repeat (5) @(posedge clk);
      run(0, 20'h00020, 1'b0, 0, 1);
      #1;
      stall = 1'b0;
      repeat (5) @(posedge clk);
   endtask

   // On-chip accesses of every kind under the slowest field.
   task automatic on_chip_access();
      set_field(SEL_SLOW);
      for (int k = 0; k < 4; k++)
      begin
         run(k, 20'h00300, 1'b1, 0, 0);
      end
      // Nine external reads ran before; on-chip reads add none.
      check("on-chip reads", 20'(n_reads), 20'h9);
   endtask

   // A slow slave stretches memory and I/O cycles, then lets go.
   task automatic ext_wait();
      int w;
      int t;
      #1;
      stall = 1'b1;
      repeat (5) @(posedge clk);
      access(2, 20'h00033, 1'b0, 3, w, t);
      check("io stretched", 20'(w >= 3 && w <= 7), 20'h1);
      check("io resumes", 20'(t), 20'h1);
      #1;
      stall = 1'b1;
      repeat (5) @(posedge clk);
      access(0, 20'h00044, 1'b0, 2, w, t);
      check("mem stretched", 20'(w >= 2 && w <= 6), 20'h1);
      check("mem resumes", 20'(t), 20'h1);
   endtask

   // ***************************************************************
   // Main sequence.
   // ***************************************************************

   initial
   begin
      rst = 1'b1;
      istb = 4'hf;
      on_chip = 1'b0;
      addr = 20'h00000;
      wdata = 8'h00;
      scr_wr = 1'b0;
      scr_data = 8'h00;
      stall = 1'b0;
      fails = 0;
      n_tests = 0;
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      reset_values();
      slow_field();
      wide_write();
      split_field();
      fast_field();
      on_chip_access();
      ext_wait();
      print_verdict();
   end
endmodule // external_bus_wait_controller_test
